// *** verilog/orre_exec.sv ***
// Execution unit for OR-to-memory, the three return forms and rotate-left of memory
// Functional notes
// RL1: OR-to-memory writes accumulator OR memory byte back to that byte and updates only zero.
// RL2: Subroutine exit pops the stacked address into the program counter, flags untouched.
// RL3: Exit-with-literal pops the program counter and loads the immediate into the accumulator.
// RL4: Interrupt exit pops the program counter and sets the master interrupt enable to 1.
// RL5: A request pending at interrupt exit is serviced before the main program resumes; the code takes it only in a cycle with EXEC_VALID low.
// RL6: While master interrupt enable is clear no interrupt is taken.
// RL7: Rotate-left moves bit i to bit i+1 for i 0 to 6 and bit 7 to bit 0.
// RL8: Every return form decrements the stack pointer by one entry.
module orre_exec
  import orre_pkg::*;
#(
  parameter int DATA_W = ORRE_DATA_W,
  parameter int PC_W   = ORRE_PC_W,
  parameter int SP_W   = ORRE_SP_W
) (
  // Clock and reset
  input  wire logic              REF_CLK,
  input  wire logic              SRST,
  // Instruction issue
  input  wire logic              EXEC_VALID,
  input  wire orre_op_t          EXEC_OP,
  input  wire logic [DATA_W-1:0] IMM_DATA,
  // Data memory read data of the addressed byte
  input  wire logic [DATA_W-1:0] MEM_RDATA,
  // Return stack top entry
  input  wire logic [PC_W-1:0]   STACK_TOP,
  // Interrupt request from the controller
  input  wire logic              IRQ_PENDING,
  // Master interrupt enable control from other instructions
  input  wire logic              MIE_CLR,
  // Data memory write back
  output logic                   MEM_WE,
  output logic [DATA_W-1:0]      MEM_WDATA,
  // Program counter load
  output logic                   PC_LOAD,
  output logic [PC_W-1:0]        PC_NEXT,
  // Accumulator and flags
  output logic [DATA_W-1:0]      ACC,
  output logic                   ZERO_FLAG,
  output logic [SP_W-1:0]        STACK_PTR,
  // Interrupt gating
  output logic                   MASTER_INTERRUPT_ENABLE,
  output logic                   IRQ_TAKE
);

  // Elaboration check of the parameter set
  if (DATA_W != 8 || PC_W < 1 || SP_W < 1) begin : g_bad_params
    $error("orre_exec: unsupported parameters");
  end

  // ----------------------------------------------------------------
  // Decode and datapath
  // ----------------------------------------------------------------
  function automatic logic is_return(input orre_op_t op);
    is_return = (op == ORRE_OP_SUBEX) || (op == ORRE_OP_LITEX) || (op == ORRE_OP_INTEX);
  endfunction

  logic [DATA_W-1:0] or_res;
  logic [DATA_W-1:0] rot_res;
  logic              do_or_mem;
  logic              do_rot;
  logic              do_exit;
  logic              do_intex;

  assign do_or_mem = EXEC_VALID && (EXEC_OP == ORRE_OP_OR_MEM);
  assign do_rot    = EXEC_VALID && (EXEC_OP == ORRE_OP_ROTL);
  assign do_exit   = EXEC_VALID && is_return(EXEC_OP);
  assign do_intex  = EXEC_VALID && (EXEC_OP == ORRE_OP_INTEX);
  assign or_res   = ACC | MEM_RDATA;                               // [RL1]
  assign rot_res  = {MEM_RDATA[DATA_W-2:0], MEM_RDATA[DATA_W-1]}; // [RL7]

  // ----------------------------------------------------------------
  // Memory write back
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      MEM_WE    <= 1'b0;
      MEM_WDATA <= ORRE_ZERO_B;
    end else begin
      MEM_WE <= do_or_mem || do_rot;
      if (do_or_mem) begin
        MEM_WDATA <= or_res;                                       // [RL1]
      end else if (do_rot) begin
        MEM_WDATA <= rot_res;                                      // [RL7]
      end
    end
  end

  // ----------------------------------------------------------------
  // Zero flag, only OR-to-memory touches it
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      ZERO_FLAG <= 1'b0;
    end else if (do_or_mem) begin
      ZERO_FLAG <= (or_res == ORRE_ZERO_B);                        // [RL1]
    end
  end

  // ----------------------------------------------------------------
  // Program counter and stack pointer
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      PC_LOAD   <= 1'b0;
      PC_NEXT   <= '0;
      STACK_PTR <= SP_W'(ORRE_SP_RST);
    end else begin
      PC_LOAD <= do_exit;
      if (do_exit) begin
        PC_NEXT   <= STACK_TOP;                                    // [RL2] [RL3] [RL4]
        STACK_PTR <= STACK_PTR - SP_W'(ORRE_SP_STEP);              // [RL8]
      end
    end
  end

  // ----------------------------------------------------------------
  // Accumulator
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      ACC <= ORRE_ACC_RST;
    end else if (EXEC_VALID && EXEC_OP == ORRE_OP_LITEX) begin
      ACC <= IMM_DATA;                                             // [RL3]
    end
  end

  // ----------------------------------------------------------------
  // Master interrupt enable and gating
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      MASTER_INTERRUPT_ENABLE <= ORRE_MIE_RST;
    end else if (do_intex) begin
      MASTER_INTERRUPT_ENABLE <= 1'b1;                             // [RL4]
    end else if (MIE_CLR || IRQ_TAKE) begin
      MASTER_INTERRUPT_ENABLE <= 1'b0;
    end
  end

  // Taken only between instructions; after interrupt exit a pending request waits for a cycle with EXEC_VALID low
  assign IRQ_TAKE = MASTER_INTERRUPT_ENABLE && IRQ_PENDING && !EXEC_VALID; // [RL5] [RL6]

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_or_write;
    @(posedge REF_CLK) disable iff (SRST)
      do_or_mem |=> MEM_WE && MEM_WDATA == ($past(ACC) | $past(MEM_RDATA));
  endproperty
  a_or_write: assert property (p_or_write) else $error("OR write back wrong"); // [RL1]

  property p_or_zero;
    @(posedge REF_CLK) disable iff (SRST)
      do_or_mem |=> ZERO_FLAG == (MEM_WDATA == ORRE_ZERO_B);
  endproperty
  a_or_zero: assert property (p_or_zero) else $error("Zero flag wrong"); // [RL1]

  property p_sub_pc;
    @(posedge REF_CLK) disable iff (SRST)
      (EXEC_VALID && EXEC_OP == ORRE_OP_SUBEX) |=>
        PC_LOAD && PC_NEXT == $past(STACK_TOP) && $stable(ZERO_FLAG) && $stable(ACC);
  endproperty
  a_sub_pc: assert property (p_sub_pc) else $error("Subroutine exit wrong"); // [RL2]

  property p_lit_acc;
    @(posedge REF_CLK) disable iff (SRST)
      (EXEC_VALID && EXEC_OP == ORRE_OP_LITEX) |=>
        ACC == $past(IMM_DATA) && PC_LOAD && $stable(ZERO_FLAG);
  endproperty
  a_lit_acc: assert property (p_lit_acc) else $error("Literal exit wrong"); // [RL3]

  property p_int_mie;
    @(posedge REF_CLK) disable iff (SRST)
      do_intex |=> MASTER_INTERRUPT_ENABLE && PC_LOAD && $stable(ZERO_FLAG);
  endproperty
  a_int_mie: assert property (p_int_mie) else $error("Interrupt exit wrong"); // [RL4]

  property p_pending;
    @(posedge REF_CLK) disable iff (SRST)
      (do_intex ##1 (IRQ_PENDING && !EXEC_VALID)) |-> IRQ_TAKE;
  endproperty
  a_pending: assert property (p_pending) else $error("Pending not serviced"); // [RL5]

  property p_gate;
    @(posedge REF_CLK) disable iff (SRST)
      !MASTER_INTERRUPT_ENABLE |-> !IRQ_TAKE;
  endproperty
  a_gate: assert property (p_gate) else $error("Interrupt taken while disabled"); // [RL6]

  property p_rot;
    @(posedge REF_CLK) disable iff (SRST)
      do_rot |=> MEM_WE && MEM_WDATA[0] == $past(MEM_RDATA[DATA_W-1])
        && MEM_WDATA[DATA_W-1:1] == $past(MEM_RDATA[DATA_W-2:0]);
  endproperty
  a_rot: assert property (p_rot) else $error("Rotate wrong"); // [RL7]

  property p_sp;
    @(posedge REF_CLK) disable iff (SRST)
      do_exit |=> STACK_PTR == $past(STACK_PTR) - SP_W'(ORRE_SP_STEP);
  endproperty
  a_sp: assert property (p_sp) else $error("Stack pointer not decremented"); // [RL8]

  property p_or_only_zero;
    @(posedge REF_CLK) disable iff (SRST)
      do_or_mem |=> $stable(ACC) && $stable(STACK_PTR) && !PC_LOAD;
  endproperty
  a_or_only_zero: assert property (p_or_only_zero) else $error("OR side effect"); // [RL1]

  property p_lit_pc;
    @(posedge REF_CLK) disable iff (SRST)
      (EXEC_VALID && EXEC_OP == ORRE_OP_LITEX) |=> PC_NEXT == $past(STACK_TOP);
  endproperty
  a_lit_pc: assert property (p_lit_pc) else $error("Literal exit target wrong"); // [RL3]

  property p_int_pc;
    @(posedge REF_CLK) disable iff (SRST)
      do_intex |=> PC_NEXT == $past(STACK_TOP) && $stable(ACC);
  endproperty
  a_int_pc: assert property (p_int_pc) else $error("Interrupt exit target wrong"); // [RL4]

  c_or_mem: cover property (@(posedge REF_CLK) disable iff (SRST) do_or_mem);
  c_rot:   cover property (@(posedge REF_CLK) disable iff (SRST) do_rot);
  c_lit:   cover property (@(posedge REF_CLK) disable iff (SRST)
                           EXEC_VALID && EXEC_OP == ORRE_OP_LITEX);
  c_ipend: cover property (@(posedge REF_CLK) disable iff (SRST) do_intex ##1 IRQ_TAKE);

endmodule

// *** verilog/orre_pkg.sv ***
// Package: opcodes, widths and reset values for the return/OR/rotate execution block
package orre_pkg;

  // ----------------------------------------------------------------
  // Operation select
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ORRE_OP_NONE   = 3'h0,
    ORRE_OP_OR_MEM = 3'h1,
    ORRE_OP_SUBEX  = 3'h2,
    ORRE_OP_LITEX  = 3'h3,
    ORRE_OP_INTEX  = 3'h4,
    ORRE_OP_ROTL   = 3'h5
  } orre_op_t;

  // ----------------------------------------------------------------
  // Sizes and reset values
  // ----------------------------------------------------------------
  localparam int          ORRE_DATA_W   = 8;
  localparam int          ORRE_PC_W     = 13;
  localparam int          ORRE_SP_W     = 3;
  localparam logic        ORRE_MIE_RST  = 1'b0;
  localparam logic [7:0]  ORRE_ACC_RST  = 8'h00;
  localparam logic [2:0]  ORRE_SP_RST   = 3'h0;
  localparam logic [2:0]  ORRE_SP_STEP  = 3'h1;
  localparam logic [7:0]  ORRE_ZERO_B   = 8'h00;

endpackage

// *** tb/or_return_rotate_exec_tb.sv ***
// Self-checking testbench for the return, OR and rotate execution block
module or_return_rotate_exec_tb import orre_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // Signals and model state
  // ----------------------------------------------------------------
  logic        ref_clk, srst, exec_valid, irq_pending, mie_clr;
  orre_op_t    exec_op;
  logic [7:0]  imm_data, mem_rdata, mem_wdata, acc, acc_m;
  logic [12:0] stack_top, pc_next;
  logic [2:0]  stack_ptr, sp_m;
  logic        mem_we, pc_load, zero_flag, mie, irq_take, mie_m, zero_m;
  logic [8:0]  mem_q[$];
  logic [24:0] exit_q[$];
  int          seed = 74;
  int          error_cnt = 0;
  int          comparisons = 0;

  orre_exec u_orre_exec (.REF_CLK(ref_clk), .SRST(srst), .EXEC_VALID(exec_valid),
    .EXEC_OP(exec_op), .IMM_DATA(imm_data), .MEM_RDATA(mem_rdata), .STACK_TOP(stack_top),
    .IRQ_PENDING(irq_pending), .MIE_CLR(mie_clr), .MEM_WE(mem_we), .MEM_WDATA(mem_wdata),
    .PC_LOAD(pc_load), .PC_NEXT(pc_next), .ACC(acc), .ZERO_FLAG(zero_flag),
    .STACK_PTR(stack_ptr), .MASTER_INTERRUPT_ENABLE(mie), .IRQ_TAKE(irq_take));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // ----------------------------------------------------------------
  // Compare and report
  // ----------------------------------------------------------------
  task automatic fail(input string what);
    error_cnt++;
    $display("[ERR] %0t %s", $time, what);
  endtask
  task automatic cmp_mem(input logic [8:0] got, input logic [8:0] exp);
    comparisons++;
    if (got !== exp) fail($sformatf("write got %h exp %h", got, exp));
  endtask
  task automatic cmp_exit(input logic [24:0] got, input logic [24:0] exp);
    comparisons++;
    if (got !== exp) fail($sformatf("return got %h exp %h", got, exp));
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) fail("interrupt gate mismatch");
  endtask
  task automatic wrap_up;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Driver: issues one instruction and notes the expected result
  // ----------------------------------------------------------------
  task automatic issue(input logic [2:0] op, input logic [7:0] rd, input logic pend, clr);
    logic [7:0]  imm;
    logic [12:0] top;
    imm = 8'($random(seed));
    top = 13'($random(seed));
    @(posedge ref_clk);
    exec_valid <= 1'b1;
    exec_op <= orre_op_t'(op);
    imm_data <= imm;
    mem_rdata <= rd;
    stack_top <= top;
    irq_pending <= pend;
    mie_clr <= clr;
    if (op == 3'h4) mie_m = 1'b1;
    else if (clr) mie_m = 1'b0;
    if (op == 3'h1) zero_m = ~|(acc_m | rd);
    if (op == 3'h1) mem_q.push_back({zero_m, acc_m | rd});
    if (op == 3'h5) mem_q.push_back({zero_m, rd[6:0], rd[7]});
    if (op == 3'h3) acc_m = imm;
    if (op >= 3'h2 && op <= 3'h4) begin
      sp_m = sp_m - 3'h1;
      exit_q.push_back({mie_m, sp_m, acc_m, top});
    end
  endtask
  task automatic idle;
    @(posedge ref_clk);
    exec_valid <= 1'b0;
    mie_clr <= 1'b0;
  endtask
  // ----------------------------------------------------------------
  // Monitor: takes the oldest note whenever a result appears
  // ----------------------------------------------------------------
  always @(negedge ref_clk) begin
    if (!srst && mem_we === 1'b1) begin
      if (mem_q.size() == 0) fail("unexpected write");
      else cmp_mem({zero_flag, mem_wdata}, mem_q.pop_front());
    end
    if (!srst && pc_load === 1'b1) begin
      if (exit_q.size() == 0) fail("unexpected return");
      else cmp_exit({mie, stack_ptr, acc, pc_next}, exit_q.pop_front());
    end
    if (!srst && exec_valid === 1'b1) cmp_bit(irq_take, 1'b0);
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {exec_valid, irq_pending, mie_clr, imm_data, mem_rdata, stack_top} = '0;
    exec_op = ORRE_OP_NONE;
    srst = 1'b1;
    {acc_m, sp_m, mie_m, zero_m} = '0;
    repeat (12) @(posedge ref_clk);
    srst <= 1'b0;
    @(negedge ref_clk);
    cmp_exit({mie, stack_ptr, acc, pc_next}, 25'h0);
    issue(3'h1, 8'h00, 1'b0, 1'b0);
    issue(3'h5, 8'h80, 1'b0, 1'b0);
    issue(3'h5, 8'h01, 1'b0, 1'b0);
    repeat (300) issue(3'($random(seed)), 8'($random(seed)), 1'($random(seed)),
      1'($random(seed)));
    idle();
    issue(3'h4, 8'h00, 1'b1, 1'b0);
    idle();
    @(negedge ref_clk);
    cmp_bit(irq_take, 1'b1);
    @(negedge ref_clk);
    cmp_bit(mie, 1'b0);
    cmp_bit(irq_take, 1'b0);
    mie_m = 1'b0;
    issue(3'h4, 8'h00, 1'b0, 1'b0);
    idle();
    @(posedge ref_clk);
    mie_clr <= 1'b1;
    @(posedge ref_clk);
    mie_clr <= 1'b0;
    @(negedge ref_clk);
    cmp_bit(mie, 1'b0);
    repeat (3) @(negedge ref_clk);
    if (mem_q.size() + exit_q.size() != 0) fail("missing result");
    wrap_up();
  end
  initial begin
    repeat (5000) @(posedge ref_clk);
    fail("timeout");
    wrap_up();
  end
endmodule
